/* shared/fps_pkg.sv */
// shared constants, types and decoding for the field pair selector
package fps_pkg;
   typedef enum logic [1:0] {FPS_FIXED_PAIR, FPS_OVERLAP, FPS_FIXED_MOMENT} fps_mode_t;
   typedef enum logic [2:0] {
      FPS_ONE_FIVE, FPS_TWO_FIVE, FPS_ONE_TEN, FPS_TWO_TEN, FPS_MATRIX, FPS_BANKS
   } fps_scheme_t;
   localparam int NUM_SEL = 10;
   localparam int GROUP_W = 5;
   localparam logic [2:0] MAX_SELECTED = 3'h2;
   localparam int CLK_KHZ = 125_000;
   localparam int SYNC_TIME_MS = 40;
   localparam int SYNC_CYCLES = SYNC_TIME_MS * CLK_KHZ;
   localparam logic [3:0] PAIR_NONE = 4'h0;
   localparam logic [3:0] PAIR_FIRST = 4'h1;
   // ten-pair patterns, bit 0 is select input one
   localparam logic [4:0] PAT_SIX = 5'h0f;
   localparam logic [4:0] PAT_SEVEN = 5'h17;
   localparam logic [4:0] PAT_EIGHT = 5'h1b;
   localparam logic [4:0] PAT_NINE = 5'h1d;
   localparam logic [4:0] PAT_TEN = 5'h1e;
   // controller register map, byte addresses
   localparam logic [3:0] REG_SEL = 4'h0;
   localparam logic [3:0] REG_TARGET = 4'h4;
   localparam logic [3:0] REG_HOLD = 4'h8;
   localparam logic [3:0] REG_STATUS = 4'hc;
   localparam int TARGET_OVL_BIT = 16;
   localparam int STATUS_BUSY_BIT = 16;
   localparam logic [31:0] HOLD_RESET = 32'h0000_0010;

   typedef struct packed {
      logic init;
      logic run;
      logic [31:0] tmr;
      logic [9:0] prev;
      logic [3:0] col;
      logic [3:0] col2;
      logic [3:0] row;
      logic [31:0] occ;
      logic newp;
   } fps_chan_t;

   // returns pair number 1..10, or PAIR_NONE for an unlisted pattern
   function automatic logic [3:0] fps_decode(input logic [4:0] g, input logic ten);
      logic [3:0] r;
      r = PAIR_NONE;
      case (g)
         5'h01: r = 4'h1;
         5'h02: r = 4'h2;
         5'h04: r = 4'h3;
         5'h08: r = 4'h4;
         5'h10: r = 4'h5;
         PAT_SIX: r = ten ? 4'h6 : PAIR_NONE;
         PAT_SEVEN: r = ten ? 4'h7 : PAIR_NONE;
         PAT_EIGHT: r = ten ? 4'h8 : PAIR_NONE;
         PAT_NINE: r = ten ? 4'h9 : PAIR_NONE;
         PAT_TEN: r = ten ? 4'ha : PAIR_NONE;
         default: r = PAIR_NONE;
      endcase
      return r;
   endfunction : fps_decode
endpackage : fps_pkg

/* shared/fps_link_if.sv */
// select input link between machine controller and sensor
`timescale 1ns/100ps
interface fps_link_if;
   logic [9:0] sel;
   modport dev (input sel);
   modport ctl (output sel);
endinterface : fps_link_if

/* hdl/fps_ctrl.sv */
// machine controller end: drives select inputs from avalon registers
`timescale 1ns/100ps
module fps_ctrl (
   input wire logic clk,
   input wire logic nrst,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   fps_link_if.ctl link
);
   import fps_pkg::*;

   typedef struct packed {
      logic [9:0] sel;
      logic [9:0] target;
      logic [31:0] hold;
      logic [31:0] cnt;
      logic busy;
      logic wait_n;
      logic [31:0] rdata;
   } fps_ctl_t;

   fps_ctl_t st_reg;
   fps_ctl_t st_next;
   logic req;
   logic acc;

   assign avs_readdata = st_reg.rdata;
   assign avs_waitrequest = st_reg.wait_n;
   assign link.sel = st_reg.sel;

   always_comb begin
      st_next = st_reg;
      req = avs_read | avs_write;
      acc = req & ~st_reg.wait_n;
      // one wait state per access, so read data can come from a flop
      st_next.wait_n = ~(req & st_reg.wait_n);
      if (req && st_reg.wait_n) begin
         unique case (avs_address)
            REG_SEL: st_next.rdata = {22'h0, st_reg.sel};
            REG_TARGET: st_next.rdata = {22'h0, st_reg.target};
            REG_HOLD: st_next.rdata = st_reg.hold;
            REG_STATUS: st_next.rdata = {15'h0000, st_reg.busy, 6'h00, st_reg.sel};
            default: st_next.rdata = 32'h0000_0000;
         endcase
      end
      if (st_reg.busy) begin
         if (st_reg.cnt == 32'h0000_0000) begin
            st_next.sel = st_reg.target;
            st_next.busy = 1'b0;
         end else begin
            st_next.cnt = st_reg.cnt - 32'h0000_0001;
         end
      end
      if (acc && avs_write) begin
         unique case (avs_address)
            REG_SEL: begin
               st_next.sel = avs_writedata[9:0];
               st_next.busy = 1'b0;
            end
            REG_TARGET: begin
               // a new target is refused while an overlap is still running
               if (!st_reg.busy) begin
                  st_next.target = avs_writedata[9:0];
                  if (avs_writedata[TARGET_OVL_BIT]) begin
                     st_next.sel = st_reg.sel | avs_writedata[9:0];
                     st_next.cnt = st_reg.hold;
                     st_next.busy = 1'b1;
                  end else begin
                     st_next.sel = avs_writedata[9:0];
                  end
               end
            end
            REG_HOLD: st_next.hold = avs_writedata;
            default: st_next.hold = st_reg.hold;
         endcase
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         st_reg <= '{sel: 10'h000, target: 10'h000, hold: HOLD_RESET, cnt: 32'h0000_0000,
                     busy: 1'b0, wait_n: 1'b1, rdata: 32'h0000_0000};
      end else begin
         st_reg <= st_next;
      end
   end
endmodule : fps_ctrl

/* hdl/fps_device.sv */
// sensor end: decodes select inputs into monitored field pairs
// Functional notes
// - fixed mode monitors first pair, ignores inputs
// - overlap mode only with five-pair schemes
// - controller adds new pair before dropping old
// - at most two pairs, both monitored
// - overlap pair active only while selected
// - overlap timer starts on second selection
// - one pair left when timer expires
// - five pairs of A are one-hot
// - inputs six to ten one-hot for B
// - fixed moment keeps old pair during timer
// - fixed moment timer starts on input change
// - new pair monitored exactly at expiry
// - controller valid pattern by expiry
// - ten-pair pattern code on five inputs
// - inputs six to ten ten-pair code for B
// - hundred pairs: column low, row high
// - low group drives A, high drives B
// - banks: high chooses bank, low pair
// - violation flags fault, outputs off
// - occupied new field: response plus sync delay
//
// Our own choices: register access over Avalon-MM and the address map.
`timescale 1ns/100ps
module fps_device #(
   parameter int unsigned SYNC_CYC = fps_pkg::SYNC_CYCLES
) (
   input wire logic clk,
   input wire logic nrst,
   fps_link_if.dev link,
   input fps_pkg::fps_mode_t mode,
   input fps_pkg::fps_scheme_t scheme,
   input wire logic [31:0] chg_cycles,
   input wire logic [31:0] resp_cycles,
   input wire logic [1:0] field_occupied,
   input wire logic fault_clear,
   output logic [3:0] pair_a_col,
   output logic [3:0] pair_a_row,
   output logic [3:0] pair_a_col2,
   output logic [3:0] pair_b_col,
   output logic [3:0] pair_b_col2,
   output logic safety_outputs_function_a,
   output logic safety_outputs_function_b,
   output logic [1:0] changeover_active,
   output logic fault
);
   import fps_pkg::*;

   typedef struct packed {
      fps_chan_t [1:0] ch;
      logic [1:0] safety_switching_output;
      logic fault;
   } fps_dev_t;

   localparam logic [31:0] SYNC_W = 32'(SYNC_CYC);

   fps_dev_t st_reg;
   fps_dev_t st_next;
   logic split;
   logic wide;
   logic ten;
   logic used;
   logic ok;
   logic cfg_bad;
   logic [1:0] viol;
   logic [4:0] g5;
   logic [9:0] grp;
   logic [3:0] col_d;
   logic [3:0] row_d;
   logic [3:0] p1;
   logic [3:0] p2;
   logic [2:0] n;
   logic [31:0] limit;
   logic off;

   assign pair_a_col = st_reg.ch[0].col;
   assign pair_a_row = st_reg.ch[0].row;
   assign pair_a_col2 = st_reg.ch[0].col2;
   assign pair_b_col = st_reg.ch[1].col;
   assign pair_b_col2 = st_reg.ch[1].col2;
   assign safety_outputs_function_a = st_reg.safety_switching_output[0];
   assign safety_outputs_function_b = st_reg.safety_switching_output[1];
   assign changeover_active = {st_reg.ch[1].run, st_reg.ch[0].run};
   assign fault = st_reg.fault;

   always_comb begin
      st_next = st_reg;
      viol = 2'b00;
      g5 = 5'h00;
      grp = 10'h000;
      col_d = PAIR_NONE;
      row_d = PAIR_NONE;
      ok = 1'b0;
      used = 1'b0;
      p1 = PAIR_NONE;
      p2 = PAIR_NONE;
      n = 3'h0;
      limit = 32'h0000_0000;
      off = 1'b0;
      split = (scheme == FPS_TWO_FIVE) || (scheme == FPS_TWO_TEN);
      wide = (scheme == FPS_MATRIX) || (scheme == FPS_BANKS);
      ten = (scheme != FPS_ONE_FIVE) && (scheme != FPS_TWO_FIVE);
      cfg_bad = (mode == FPS_OVERLAP) && ten;
      for (int c = 0; c < 2; c++) begin
         used = (c == 0) || split;
         g5 = (c == 1) ? link.sel[9:5] : link.sel[4:0];
         grp = wide ? link.sel : {5'h00, g5};
         col_d = fps_decode(g5, ten);
         // row or bank from high group
         row_d = wide ? fps_decode(link.sel[9:5], 1'b1) : PAIR_FIRST;
         ok = (col_d != PAIR_NONE) && (row_d != PAIR_NONE);
         p1 = PAIR_NONE;
         p2 = PAIR_NONE;
         n = 3'h0;
         for (int i = 0; i < GROUP_W; i++) begin
            if (g5[i]) begin
               n = n + 3'h1;
               if (p1 == PAIR_NONE) begin
                  p1 = 4'(i + 1);
               end
               p2 = 4'(i + 1);
            end
         end
         if (!used) begin
            st_next.ch[c] = '0;
         end else if (mode == FPS_FIXED_PAIR) begin
            st_next.ch[c].col = PAIR_FIRST;
            st_next.ch[c].row = PAIR_FIRST;
            st_next.ch[c].col2 = PAIR_NONE;
            st_next.ch[c].run = 1'b0;
            st_next.ch[c].init = 1'b0;
         end else if (st_reg.fault) begin
            // nothing monitored until cleared, then pairs are adopted afresh
            st_next.ch[c].init = 1'b1;
            st_next.ch[c].run = 1'b0;
            st_next.ch[c].col = PAIR_NONE;
            st_next.ch[c].col2 = PAIR_NONE;
         end else if (st_reg.ch[c].init) begin
            if (ok) begin
               st_next.ch[c].init = 1'b0;
               st_next.ch[c].col = col_d;
               st_next.ch[c].row = row_d;
               st_next.ch[c].prev = grp;
            end
         end else if (mode == FPS_OVERLAP) begin
            if (n == 3'h1) begin
               if (st_reg.ch[c].run) begin
                  // only the still selected pair remains
                  st_next.ch[c].run = 1'b0;
                  st_next.ch[c].col = p1;
                  st_next.ch[c].col2 = PAIR_NONE;
                  st_next.ch[c].prev = grp;
               end else if (grp != st_reg.ch[c].prev) begin
                  viol[c] = 1'b1;
               end
            end else if (n == MAX_SELECTED) begin
               if (!st_reg.ch[c].run) begin
                  if ((grp & st_reg.ch[c].prev) == st_reg.ch[c].prev) begin
                     st_next.ch[c].run = 1'b1;
                     st_next.ch[c].tmr = chg_cycles;
                     st_next.ch[c].col = p1;
                     st_next.ch[c].col2 = p2;
                     st_next.ch[c].prev = grp;
                  end else begin
                     viol[c] = 1'b1;
                  end
               end else if (grp != st_reg.ch[c].prev) begin
                  viol[c] = 1'b1;
               end else if (st_reg.ch[c].tmr == 32'h0000_0000) begin
                  viol[c] = 1'b1;
               end else begin
                  st_next.ch[c].tmr = st_reg.ch[c].tmr - 32'h0000_0001;
               end
            end else begin
               viol[c] = 1'b1;
            end
         end else begin
            if (!st_reg.ch[c].run) begin
               if (grp != st_reg.ch[c].prev) begin
                  st_next.ch[c].run = 1'b1;
                  st_next.ch[c].tmr = chg_cycles;
               end else if (!ok) begin
                  viol[c] = 1'b1;
               end
            end else if (st_reg.ch[c].tmr == 32'h0000_0000) begin
               st_next.ch[c].run = 1'b0;
               st_next.ch[c].prev = grp;
               if (ok) begin
                  st_next.ch[c].col = col_d;
                  st_next.ch[c].row = row_d;
               end else begin
                  viol[c] = 1'b1;
               end
            end else begin
               // old pair stays, inputs may settle meanwhile
               st_next.ch[c].tmr = st_reg.ch[c].tmr - 32'h0000_0001;
            end
         end
         if (field_occupied[c] && (st_reg.ch[c].col != PAIR_NONE)) begin
            if (st_reg.ch[c].occ != 32'hffff_ffff) begin
               st_next.ch[c].occ = st_reg.ch[c].occ + 32'h0000_0001;
            end
            if (st_next.ch[c].col != st_reg.ch[c].col) begin
               st_next.ch[c].newp = 1'b1;
            end
         end else begin
            st_next.ch[c].occ = 32'h0000_0000;
            st_next.ch[c].newp = 1'b0;
         end
         // extra sync delay after changing into an occupied field
         limit = resp_cycles + (st_reg.ch[c].newp ? SYNC_W : 32'h0000_0000);
         off = field_occupied[c] && (st_reg.ch[c].occ >= limit);
         st_next.safety_switching_output[c] = used && (st_next.ch[c].col != PAIR_NONE) && !off;
      end
      // sticky fault, set wins over clear
      st_next.fault = (st_reg.fault && !fault_clear) || (|viol) || cfg_bad;
      if (st_next.fault) begin
         st_next.safety_switching_output = 2'b00;
         // pairs dropped on the same edge, so no col output shows a stale pair; pair_a_row keeps its value
         for (int c = 0; c < 2; c++) begin
            st_next.ch[c].col = PAIR_NONE;
            st_next.ch[c].col2 = PAIR_NONE;
            st_next.ch[c].run = 1'b0;
            st_next.ch[c].init = 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         st_reg <= '{ch: {2{fps_chan_t'{init: 1'b1, default: '0}}}, safety_switching_output: 2'b00, fault: 1'b0};
      end else begin
         st_reg <= st_next;
      end
   end
endmodule : fps_device

/* verif/fps_link_sva.sv */
// assertions on the select link and the sensor outputs
`timescale 1ns/100ps
module fps_link_sva
   import fps_pkg::*;
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic [9:0] sel,
   input fps_pkg::fps_mode_t mode,
   input fps_pkg::fps_scheme_t scheme,
   input wire logic [31:0] chg_cycles,
   input wire logic fault_clear,
   input wire logic [3:0] pair_a_col,
   input wire logic [3:0] pair_a_col2,
   input wire logic [3:0] pair_b_col,
   input wire logic safety_outputs_function_a,
   input wire logic safety_outputs_function_b,
   input wire logic [1:0] changeover_active,
   input wire logic fault
);
   logic [31:0] run_cnt_reg;
   // counts samples with the function a timer running
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         run_cnt_reg <= 32'h0;
      end else if (changeover_active[0]) begin
         run_cnt_reg <= run_cnt_reg + 32'h1;
      end else begin
         run_cnt_reg <= 32'h0;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   property p_fixed_first;
      mode == FPS_FIXED_PAIR && $past(nrst) && !$past(fault_clear) && !fault
         |-> pair_a_col == PAIR_FIRST;
   endproperty
   property p_fault_off;
      fault |-> !safety_outputs_function_a && !safety_outputs_function_b
         && pair_a_col == PAIR_NONE;
   endproperty
   property p_fault_sticky;
      fault && !fault_clear |=> fault;
   endproperty
   property p_fm_change;
      mode == FPS_FIXED_MOMENT && !fault && $past(pair_a_col) != PAIR_NONE
         && pair_a_col != $past(pair_a_col) |-> $past(changeover_active[0])
         && !changeover_active[0];
   endproperty
   property p_fm_len;
      mode == FPS_FIXED_MOMENT && !fault && $fell(changeover_active[0])
         |-> run_cnt_reg == chg_cycles + 32'h1;
   endproperty
   property p_ovl_two;
      mode == FPS_OVERLAP && !fault && $countones(sel[4:0]) == 2
         && $countones($past(sel[4:0])) == 2 |-> pair_a_col2 != PAIR_NONE;
   endproperty
   property p_ovl_one;
      mode == FPS_OVERLAP && !fault && $countones(sel[4:0]) == 1 && $stable(sel[4:0])
         |-> pair_a_col2 == PAIR_NONE;
   endproperty
   property p_b_idle;
      scheme != FPS_TWO_FIVE && scheme != FPS_TWO_TEN
         |-> !safety_outputs_function_b && pair_b_col == PAIR_NONE;
   endproperty
   a_fixed_first: assert property (p_fixed_first)
      else $error("fixed mode left the first pair");
   a_fault_off: assert property (p_fault_off)
      else $error("outputs on during fault");
   a_fault_sticky: assert property (p_fault_sticky)
      else $error("fault cleared by itself");
   a_fm_change: assert property (p_fm_change)
      else $error("pair changed before timer expiry");
   a_fm_len: assert property (p_fm_len)
      else $error("changeover timer length wrong");
   a_ovl_two: assert property (p_ovl_two)
      else $error("second pair not monitored");
   a_ovl_one: assert property (p_ovl_one)
      else $error("unselected pair still monitored");
   a_b_idle: assert property (p_b_idle)
      else $error("function b active in one-function scheme");
   c_fault: cover property ($rose(fault));
   c_ovl: cover property (pair_a_col2 != PAIR_NONE);
   c_fm: cover property (mode == FPS_FIXED_MOMENT && $fell(changeover_active[0]));
endmodule : fps_link_sva

/* verif/tb_field_pair_selector.sv */
// self-checking bench joining controller and sensor ends
`timescale 1ns/100ps
module tb_field_pair_selector;
   import fps_pkg::*;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic [3:0] avs_address = 4'h0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   fps_mode_t mode = FPS_FIXED_PAIR;
   fps_scheme_t scheme = FPS_ONE_FIVE;
   logic [31:0] chg_cycles = 32'h6;
   logic [31:0] resp_cycles = 32'h4;
   logic [1:0] field_occupied = 2'h0;
   logic fault_clear = 1'b0;
   logic [3:0] pair_a_col;
   logic [3:0] pair_a_row;
   logic [3:0] pair_a_col2;
   logic [3:0] pair_b_col;
   logic [3:0] pair_b_col2;
   logic safety_outputs_function_a;
   logic safety_outputs_function_b;
   logic [1:0] changeover_active;
   logic fault;
   logic [31:0] rdata;
   logic [9:0] r;
   int error_cnt = 0;
   int samples_checked = 0;
   // pattern of pair n at index n-1, input one in bit 0
   int pat[10] = '{1, 2, 4, 8, 16, 15, 23, 27, 29, 30};
   int a, b, pa, pb;
   fps_scheme_t wide[3] = '{FPS_TWO_TEN, FPS_MATRIX, FPS_BANKS};
   always #4 clk = ~clk;
   fps_link_if link ();
   fps_ctrl i_fps_ctrl (.clk, .nrst, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_readdata, .avs_waitrequest, .link(link));
   fps_device #(.SYNC_CYC(20)) i_fps_device (.clk, .nrst, .link(link), .mode, .scheme,
      .chg_cycles, .resp_cycles, .field_occupied, .fault_clear, .pair_a_col, .pair_a_row,
      .pair_a_col2, .pair_b_col, .pair_b_col2, .safety_outputs_function_a,
      .safety_outputs_function_b, .changeover_active, .fault);
   fps_link_sva i_fps_link_sva (.clk, .nrst, .sel(link.sel), .mode, .scheme, .chg_cycles,
      .fault_clear, .pair_a_col, .pair_a_col2, .pair_b_col, .safety_outputs_function_a,
      .safety_outputs_function_b, .changeover_active, .fault);
   task automatic chk_pair(input string nm, input logic [3:0] e, input logic [3:0] g);
      samples_checked++;
      if (g !== e) begin
         error_cnt++;
         $display("[ERR] %s expected %0d seen %0d", nm, e, g);
      end
   endtask : chk_pair
   task automatic chk_bit(input string nm, input logic e, input logic g);
      samples_checked++;
      if (g !== e) begin
         error_cnt++;
         $display("[ERR] %s expected %b seen %b", nm, e, g);
      end
   endtask : chk_bit
   task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk_word
   // holds the request until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [3:0] ad, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      avs_address <= ad;
      avs_write <= wr;
      avs_read <= !wr;
      avs_writedata <= d;
      do begin
         @(posedge clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 100);
      if (n >= 100) error_cnt++;
      rdata = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask : bus
   task automatic rst(input fps_mode_t m, input fps_scheme_t s);
      nrst <= 1'b0;
      mode <= m;
      scheme <= s;
      field_occupied <= 2'h0;
      repeat (6) @(posedge clk);
      nrst <= 1'b1;
   endtask : rst
   task automatic sel_wait(input logic [9:0] v);
      bus(1'b1, REG_SEL, {22'h0, v});
      repeat (12) @(posedge clk);
   endtask : sel_wait
   task automatic finish_test;
      $display("checked %0d, mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : finish_test
   initial begin
      repeat (20000) @(posedge clk);
      error_cnt++;
      finish_test;
   end
   initial begin
      void'($urandom(66));
      rst(FPS_FIXED_PAIR, FPS_TWO_FIVE);
      bus(1'b0, REG_HOLD, 32'h0);
      chk_word("hold", HOLD_RESET, rdata);
      r = 10'($urandom_range(1023));
      sel_wait(r);
      chk_pair("a_col", 4'h1, pair_a_col);
      chk_pair("b_col", 4'h1, pair_b_col);
      bus(1'b0, 4'h2, 32'h0);
      chk_word("unmapped", 32'h0, rdata);
      bus(1'b0, REG_STATUS, 32'h0);
      chk_word("status", {22'h0, r}, rdata);
      $display("fixed pair test done");
      rst(FPS_FIXED_MOMENT, FPS_ONE_TEN);
      sel_wait(10'h001);
      pa = 1;
      for (int i = 9; i >= 0; i--) begin
         bus(1'b1, REG_SEL, 32'(pat[i]));
         repeat (3) @(posedge clk);
         chk_pair("a_col_old", 4'(pa), pair_a_col);
         repeat (8) @(posedge clk);
         chk_pair("a_col_new", 4'(i + 1), pair_a_col);
         pa = i + 1;
      end
      chk_bit("fault", 1'b0, fault);
      $display("ten pattern test done");
      for (int s = 0; s < 3; s++) begin
         rst(FPS_FIXED_MOMENT, wide[s]);
         for (int k = 0; k < 4; k++) begin
            a = $urandom_range(9);
            b = $urandom_range(9);
            sel_wait({pat[b][4:0], pat[a][4:0]});
            chk_pair("a_col", 4'(a + 1), pair_a_col);
            if (s == 0) chk_pair("b_col", 4'(b + 1), pair_b_col);
            else chk_pair("a_row", 4'(b + 1), pair_a_row);
         end
      end
      $display("wide scheme test done");
      rst(FPS_OVERLAP, FPS_TWO_FIVE);
      sel_wait(10'h021);
      bus(1'b1, REG_HOLD, 32'h3);
      pa = 0;
      pb = 0;
      for (int k = 0; k < 6; k++) begin
         pa = (pa + 1 + $urandom_range(3)) % 5;
         pb = (pb + 1 + $urandom_range(3)) % 5;
         bus(1'b1, REG_TARGET, 32'h10000 | (32'h20 << pb) | (32'h1 << pa));
         repeat (2) @(posedge clk);
         chk_bit("a_two", 1'b1, pair_a_col2 != PAIR_NONE);
         repeat (10) @(posedge clk);
         chk_pair("a_col", 4'(pa + 1), pair_a_col);
         chk_pair("b_col", 4'(pb + 1), pair_b_col);
         chk_pair("a_col2", PAIR_NONE, pair_a_col2);
         chk_pair("b_col2", PAIR_NONE, pair_b_col2);
      end
      chk_bit("fault", 1'b0, fault);
      $display("overlap test done");
      rst(FPS_FIXED_MOMENT, FPS_ONE_FIVE);
      sel_wait(10'h001);
      sel_wait(10'h003);
      chk_bit("fault", 1'b1, fault);
      chk_bit("out_a", 1'b0, safety_outputs_function_a);
      sel_wait(10'h002);
      fault_clear <= 1'b1;
      @(posedge clk);
      fault_clear <= 1'b0;
      repeat (4) @(posedge clk);
      chk_bit("fault_clr", 1'b0, fault);
      chk_pair("a_col", 4'h2, pair_a_col);
      rst(FPS_OVERLAP, FPS_ONE_TEN);
      repeat (4) @(posedge clk);
      chk_bit("fault_ten", 1'b1, fault);
      $display("fault test done");
      rst(FPS_FIXED_PAIR, FPS_ONE_FIVE);
      repeat (4) @(posedge clk);
      field_occupied <= 2'h1;
      repeat (3) @(posedge clk);
      chk_bit("out_a_early", 1'b1, safety_outputs_function_a);
      repeat (6) @(posedge clk);
      chk_bit("out_a_off", 1'b0, safety_outputs_function_a);
      field_occupied <= 2'h0;
      repeat (3) @(posedge clk);
      chk_bit("out_a_on", 1'b1, safety_outputs_function_a);
      // change into an occupied field: response time plus sync time
      rst(FPS_FIXED_MOMENT, FPS_ONE_FIVE);
      sel_wait(10'h001);
      bus(1'b1, REG_SEL, 32'h2);
      field_occupied <= 2'h1;
      repeat (12) @(posedge clk);
      chk_bit("out_a_sync", 1'b1, safety_outputs_function_a);
      chk_pair("a_col_occ", 4'h2, pair_a_col);
      repeat (18) @(posedge clk);
      chk_bit("out_a_sync_off", 1'b0, safety_outputs_function_a);
      field_occupied <= 2'h0;
      $display("occupancy test done");
      finish_test;
   end
endmodule : tb_field_pair_selector
